// ---- hdl/pps_pkg.sv ----
package pps_pkg;

  // ----------------------------------------------------------------
  // Register offsets (word addresses on the serial register port)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CHAN_PWR = 8'h04;
  localparam logic [7:0] ADDR_PLL_PWR = 8'h05;
  localparam logic [7:0] ADDR_CAL_WORD = 8'h06;
  localparam logic [7:0] ADDR_FLAGS = 8'h07;
  localparam logic [7:0] ADDR_MISC = 8'h08;
  localparam logic [7:0] ADDR_LIVE_CRC = 8'h09;
  localparam logic [7:0] ADDR_STORED_CRC = 8'h0a;
  // Highest implemented register address of the device
  localparam logic [7:0] ADDR_LAST = 8'h3f;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] RST_CHAN_PWR = 16'h0054;
  localparam logic [15:0] RST_PLL_PWR = 16'h0030;
  localparam logic [15:0] RST_ZERO = 16'h0000;

  // ----------------------------------------------------------------
  // Channel power field positions
  // ----------------------------------------------------------------
  localparam int CH1_OFF_BIT = 1;
  localparam int CH2_OFF_BIT = 3;
  localparam int CH3_OFF_BIT = 5;
  localparam int CH4_OFF_BIT = 7;

  // ----------------------------------------------------------------
  // PLL power field positions
  // ----------------------------------------------------------------
  localparam int BUF2_OFF_BIT = 10;
  localparam int VCO_OFF_BIT = 9;
  localparam int VBUF_OFF_BIT = 8;
  localparam int CP_OFF_BIT = 7;
  localparam int LOCKDET_OFF_BIT = 6;
  localparam int PSB_OFF_BIT = 5;
  localparam int PSA_OFF_BIT = 4;
  localparam int PFD_OFF_BIT = 2;
  localparam int PS_OFF_BIT = 1;
  localparam int INPATH_OFF_BIT = 0;

  // ----------------------------------------------------------------
  // Flag register field positions
  // ----------------------------------------------------------------
  localparam int LOCK_LIVE_BIT = 11;
  localparam int VBUF_POR_BIT = 10;
  localparam int NVM_RD_ERR_BIT = 9;
  localparam int NVM_WR_ERR_BIT = 8;
  localparam int BUS_RD_ERR_BIT = 7;
  localparam int BUS_WR_ERR_BIT = 6;
  localparam int CRC_ERR_BIT = 5;
  localparam int NVM_BUSY_BIT = 4;
  localparam int CAL_DONE_BIT = 3;
  localparam int CFG_DONE_BIT = 2;
  localparam int LOCK_LOST_BIT = 1;
  localparam int FREQ_LOCK_BIT = 0;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  // Register port request, one cycle strobes
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [15:0] wdata;
  } pps_req_s;

  // Analog and engine status inputs
  typedef struct packed {
    logic [15:0] cal_word;
    logic [15:0] misc;
    logic [15:0] live_crc;
    logic [15:0] stored_crc;
    logic lock_live;
    logic vbuf_por;
    logic freq_lock;
    logic cal_done;
    logic cfg_done;
    logic nvm_busy;
    logic nvm_rd_phase;
    logic nvm_wr_phase;
    logic nvm_op_req;
    logic crc_fail;
    logic nvm_load_req;
    logic crc_update_req;
    logic lock_lost_evt;
    logic recal;
    logic cal_complete_evt;
  } pps_stat_s;

endpackage : pps_pkg

// ---- hdl/pps_regs.sv ----
// Functional notes
// RQ1: Channel bits 1,3,5,7 power down regulators
// RQ2: Channel register resets to 0x54
// RQ3: Bits 10,9,8 power down oscillator parts
// RQ4: Bits 7,6 power down pump, lock detector
// RQ5: Prescaler B/A bits reset high, 0x30
// RQ6: Phase detector off until calibration completes; code leaves it on through reset, PPS_POR and the first PPS_CAL cycle
// RQ7: Prescaler enabled in reset, off afterwards
// RQ8: Host never sets input-path kill bit
// RQ9: Offset 6 read-only calibration word
// RQ10: Flag bit 11 shows live lock
// RQ11: Flag bit 10 shows buffer regulator POR
// RQ12: NVM op during read phase; read clears
// RQ13: NVM op during write phase; read clears
// RQ14: Bit 7 flags out-of-range read
// RQ15: Bit 6 flags out-of-range write
// RQ16: CRC fail sets; load or update clears
// RQ17: Busy flag high during NVM operations
// RQ18: Bit 3 set after both calibrations
// RQ19: Bit 2 set after configuration complete
// RQ20: Sticky lock loss, cleared by recal/reset
// RQ21: Bit 0 reports frequency lock
// RQ22: Offset 9 read-only live CRC
// RQ23: Host waits busy low before CRC read
// RQ24: Writes to read-only fields are ignored
`timescale 1ns/1ps
module pps_regs (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire pps_pkg::pps_req_s req,
  input wire pps_pkg::pps_stat_s stat_in,
  output logic [15:0] rdata,
  output logic rvalid,
  output logic [15:0] chan_pwr,
  output logic [15:0] pll_pwr,
  output logic chan_one_regulator_off,
  output logic chan_two_regulator_off,
  output logic chan_three_regulator_off,
  output logic chan_four_regulator_off,
  output logic osc_buffer2_regulator_off,
  output logic charge_pump_regulator_off
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  // Power-up phase of the prescaler and phase detector controls
  typedef enum logic [1:0] {
    PPS_POR,
    PPS_CAL,
    PPS_RUN
  } pps_phase_e;

  // Block state other than the synchroniser flops in one record
  typedef struct packed {
    pps_phase_e phase;
    logic [15:0] chan;
    logic [15:0] pll;
    logic nvm_rd_err;
    logic nvm_wr_err;
    logic bus_rd_err;
    logic bus_wr_err;
    logic crc_err;
    logic lock_lost;
    logic [15:0] rdata;
    logic rvalid;
  } pps_state_s;

  pps_state_s st_q;  // Registered state
  pps_state_s st_d;  // Next state

  // Status inputs from other domains, two-flop synchronised
  pps_pkg::pps_stat_s s1_q;  // First stage, read only by s2
  pps_pkg::pps_stat_s s2_q;  // Second stage, used by logic
  logic [15:0] flags;  // Assembled flag word

  // ----------------------------------------------------------------
  // Synchroniser
  // ----------------------------------------------------------------
  // Multi-bit words are assumed quasi-static while sampled
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      s1_q <= '0;
      s2_q <= '0;
    end else if (clk_en) begin
      s1_q <= stat_in;
      s2_q <= s1_q;
    end
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Address lies above the last implemented register
  function automatic logic out_of_range(input logic [7:0] a);
    out_of_range = (a > pps_pkg::ADDR_LAST);
  endfunction : out_of_range

  // Flag word view; upper reserved bits read zero
  always_comb begin
    flags = pps_pkg::RST_ZERO;
    flags[pps_pkg::LOCK_LIVE_BIT] = s2_q.lock_live;  // RQ10
    flags[pps_pkg::VBUF_POR_BIT] = s2_q.vbuf_por;  // RQ11
    flags[pps_pkg::NVM_RD_ERR_BIT] = st_q.nvm_rd_err;
    flags[pps_pkg::NVM_WR_ERR_BIT] = st_q.nvm_wr_err;
    flags[pps_pkg::BUS_RD_ERR_BIT] = st_q.bus_rd_err;
    flags[pps_pkg::BUS_WR_ERR_BIT] = st_q.bus_wr_err;
    flags[pps_pkg::CRC_ERR_BIT] = st_q.crc_err;
    flags[pps_pkg::NVM_BUSY_BIT] = s2_q.nvm_busy;  // RQ17
    flags[pps_pkg::CAL_DONE_BIT] = s2_q.cal_done;  // RQ18
    flags[pps_pkg::CFG_DONE_BIT] = s2_q.cfg_done;  // RQ19
    flags[pps_pkg::LOCK_LOST_BIT] = st_q.lock_lost;
    flags[pps_pkg::FREQ_LOCK_BIT] = s2_q.freq_lock;  // RQ21
  end

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    logic rd_flags;
    rd_flags = req.rd && (req.addr == pps_pkg::ADDR_FLAGS);
    st_d = st_q;
    st_d.rvalid = req.rd;
    // Register writes; read-only offsets fall through untouched
    if (req.wr) begin
      case (req.addr)
        pps_pkg::ADDR_CHAN_PWR: st_d.chan = req.wdata;  // RQ1
        pps_pkg::ADDR_PLL_PWR: st_d.pll = req.wdata;  // RQ3 RQ4
        default: st_d.chan = st_q.chan;  // RQ24
      endcase
    end
    // Power-up sequencing of prescaler and phase detector
    case (st_q.phase)
      PPS_POR: begin
        // Prescaler powered down as the power-on phase ends
        st_d.pll[pps_pkg::PS_OFF_BIT] = 1'b1;  // RQ7
        st_d.phase = PPS_CAL;
      end
      PPS_CAL: begin
        // Phase detector held off until calibration ends
        st_d.pll[pps_pkg::PFD_OFF_BIT] = 1'b1;  // RQ6
        if (s2_q.cal_complete_evt) begin
          st_d.pll[pps_pkg::PFD_OFF_BIT] = 1'b0;  // RQ6
          st_d.phase = PPS_RUN;
        end
      end
      PPS_RUN: st_d.phase = PPS_RUN;
      default: st_d.phase = PPS_POR;
    endcase
    // Read-clear NVM errors; a new event wins over the clear
    if (rd_flags) begin
      st_d.nvm_rd_err = 1'b0;
      st_d.nvm_wr_err = 1'b0;
    end
    if (s2_q.nvm_op_req && s2_q.nvm_rd_phase) begin
      st_d.nvm_rd_err = 1'b1;  // RQ12
    end
    if (s2_q.nvm_op_req && s2_q.nvm_wr_phase) begin
      st_d.nvm_wr_err = 1'b1;  // RQ13
    end
    // Out-of-range bus accesses
    if (req.rd && out_of_range(req.addr)) begin
      st_d.bus_rd_err = 1'b1;  // RQ14
    end
    if (req.wr && out_of_range(req.addr)) begin
      st_d.bus_wr_err = 1'b1;  // RQ15
    end
    // CRC error: cleared by load or update, failure wins
    if (s2_q.nvm_load_req || s2_q.crc_update_req) begin
      st_d.crc_err = 1'b0;  // RQ16
    end
    if (s2_q.crc_fail) begin
      st_d.crc_err = 1'b1;  // RQ16
    end
    // Sticky lock loss; only recal or hard reset clears it
    if (s2_q.recal) begin
      st_d.lock_lost = 1'b0;  // RQ20
    end
    if (s2_q.lock_lost_evt) begin
      st_d.lock_lost = 1'b1;  // RQ20
    end
    // Read data mux, registered
    case (req.addr)
      pps_pkg::ADDR_CHAN_PWR: st_d.rdata = st_q.chan;
      pps_pkg::ADDR_PLL_PWR: st_d.rdata = st_q.pll;
      pps_pkg::ADDR_CAL_WORD: st_d.rdata = s2_q.cal_word;  // RQ9
      pps_pkg::ADDR_FLAGS: st_d.rdata = flags;
      pps_pkg::ADDR_MISC: st_d.rdata = s2_q.misc;
      pps_pkg::ADDR_LIVE_CRC: st_d.rdata = s2_q.live_crc;  // RQ22
      pps_pkg::ADDR_STORED_CRC: st_d.rdata = s2_q.stored_crc;
      default: st_d.rdata = pps_pkg::RST_ZERO;
    endcase
    if (!req.rd) begin
      st_d.rdata = st_q.rdata;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Prescaler bit starts low so it is enabled during reset
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      st_q <= '0;
      st_q.phase <= PPS_POR;
      st_q.chan <= pps_pkg::RST_CHAN_PWR;  // RQ2
      st_q.pll <= pps_pkg::RST_PLL_PWR;  // RQ5
    end else if (clk_en) begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // The input-path kill bit is passed as written; software must not set it
  assign chan_pwr = st_q.chan;
  assign pll_pwr = st_q.pll;  // RQ8
  assign rdata = st_q.rdata;
  assign rvalid = st_q.rvalid;
  assign chan_one_regulator_off = st_q.chan[pps_pkg::CH1_OFF_BIT];  // RQ1
  assign chan_two_regulator_off = st_q.chan[pps_pkg::CH2_OFF_BIT];
  assign chan_three_regulator_off = st_q.chan[pps_pkg::CH3_OFF_BIT];
  assign chan_four_regulator_off = st_q.chan[pps_pkg::CH4_OFF_BIT];
  assign osc_buffer2_regulator_off = st_q.pll[pps_pkg::BUF2_OFF_BIT];  // RQ3
  assign charge_pump_regulator_off = st_q.pll[pps_pkg::CP_OFF_BIT];  // RQ4

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence rd_flag_seq;
    clk_en && req.rd && req.addr == pps_pkg::ADDR_FLAGS;
  endsequence

  chan_reset_val_a: assert property (@(posedge sys_clk) // RQ2
    !rst_n |=> chan_pwr == pps_pkg::RST_CHAN_PWR)
    else $error("channel register reset value wrong");

  pll_reset_val_a: assert property (@(posedge sys_clk) // RQ5
    !rst_n |=> pll_pwr == pps_pkg::RST_PLL_PWR)
    else $error("pll register reset value wrong");

  chan_write_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ1
    clk_en && req.wr && req.addr == pps_pkg::ADDR_CHAN_PWR
    |=> chan_one_regulator_off == $past(req.wdata[pps_pkg::CH1_OFF_BIT]))
    else $error("channel write not taken");

  ro_write_ign_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ24
    clk_en && req.wr && req.addr == pps_pkg::ADDR_CAL_WORD
    |=> $stable(chan_pwr))
    else $error("read-only write changed state");

  bus_rd_err_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ14
    clk_en && req.rd && req.addr > pps_pkg::ADDR_LAST |=> st_q.bus_rd_err)
    else $error("out-of-range read not flagged");

  bus_wr_err_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ15
    clk_en && req.wr && req.addr > pps_pkg::ADDR_LAST |=> st_q.bus_wr_err)
    else $error("out-of-range write not flagged");

  nvm_rd_clr_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ12
    rd_flag_seq ##0 !(s2_q.nvm_op_req && s2_q.nvm_rd_phase) |=> !st_q.nvm_rd_err)
    else $error("nvm read error not cleared by read");

  nvm_wr_set_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ13
    clk_en && s2_q.nvm_op_req && s2_q.nvm_wr_phase |=> st_q.nvm_wr_err)
    else $error("nvm write error not set");

  crc_err_set_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ16
    clk_en && s2_q.crc_fail |=> st_q.crc_err)
    else $error("crc error not set");

  lock_sticky_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ20
    st_q.lock_lost && !s2_q.recal |=> st_q.lock_lost)
    else $error("lock loss flag dropped");

  pfd_held_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ6
    st_q.phase == PPS_CAL ##1 st_q.phase == PPS_CAL |-> pll_pwr[pps_pkg::PFD_OFF_BIT])
    else $error("phase detector on before calibration");

  // Anchored on a live edge, so the last reset edge never counts as the step
  ps_off_after_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ7
    clk_en && st_q.phase == PPS_POR |=> pll_pwr[pps_pkg::PS_OFF_BIT])
    else $error("prescaler not powered down after reset");

endmodule : pps_regs

// ---- verif/pps_host_model.sv ----
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Serial host model on the register port
// ----------------------------------------------------------------
module pps_host_model (
  input wire logic sys_clk,
  input wire logic [15:0] rdata,
  input wire logic rvalid,
  output pps_pkg::pps_req_s req
);
  // Quiet port at time zero
  initial begin
    req = '0;
  end

  // One-cycle write strobe; data inverted once released
  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    req.addr <= a;
    // Input-path kill bit is never set by this host
    req.wdata <= (a == pps_pkg::ADDR_PLL_PWR) ? (d & 16'hfffe) : d;
    req.wr <= 1'b1;
    @(posedge sys_clk);
    req.wr <= 1'b0;
    req.wdata <= ~d;
  endtask : wr_reg

  // One-cycle read strobe; answer sampled once its edge has landed
  task automatic rd_reg(input logic [7:0] a, output logic [15:0] d, output logic v);
    @(posedge sys_clk);
    req.addr <= a;
    req.rd <= 1'b1;
    @(posedge sys_clk);
    req.rd <= 1'b0;
    #1;
    v = rvalid;
    d = rdata;
  endtask : rd_reg

  // Poll busy flag, bounded, before touching the live checksum
  task automatic wait_idle(output logic ok);
    logic [15:0] d;
    logic v;
    ok = 1'b0;
    for (int i = 0; i < 16 && !ok; i++) begin
      rd_reg(pps_pkg::ADDR_FLAGS, d, v);
      ok = (d[pps_pkg::NVM_BUSY_BIT] === 1'b0);
    end
  endtask : wait_idle
endmodule : pps_host_model

// ---- verif/pps_regs_tb.sv ----
`timescale 1ns/1ps
module pps_regs_tb;
  // ----------------------------------------------------------------
  // Stimulus and observation
  // ----------------------------------------------------------------
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic clk_en = 1'b1;
  pps_pkg::pps_req_s req;
  pps_pkg::pps_stat_s stat = '0;
  logic [15:0] rdata, chan_pwr, pll_pwr, rd;
  logic rvalid, ch1, ch2, ch3, ch4, buf2, cp, v, ok;
  int err_count = 0;
  int checks_done = 0;
  // Event bits sit at the low end of the status carrier
  localparam int EV_CAL = 0, EV_RECAL = 1, EV_LOST = 2, EV_UPD = 3, EV_LOAD = 4, EV_FAIL = 5;
  localparam int EV_OP = 6;

  // 20 MHz clock
  always #25 sys_clk = ~sys_clk;

  pps_regs i_pps_regs (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en), .req(req),
    .stat_in(stat), .rdata(rdata), .rvalid(rvalid), .chan_pwr(chan_pwr),
    .pll_pwr(pll_pwr), .chan_one_regulator_off(ch1), .chan_two_regulator_off(ch2),
    .chan_three_regulator_off(ch3), .chan_four_regulator_off(ch4),
    .osc_buffer2_regulator_off(buf2), .charge_pump_regulator_off(cp));

  pps_host_model i_pps_host_model (.sys_clk(sys_clk), .rdata(rdata), .rvalid(rvalid),
    .req(req));

  // ----------------------------------------------------------------
  // Shared helpers
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // Read and judge both the word and its one-cycle valid
  task automatic rd_chk(input string what, input logic [7:0] a, input logic [15:0] exp);
    i_pps_host_model.rd_reg(a, rd, v);
    chk(what, rd, exp);
    chk("rvalid", {15'h0000, v}, 16'h0001);
  endtask : rd_chk

  // Hold an event for one cycle, then let the two-flop path settle
  task automatic pulse(input int b);
    @(posedge sys_clk);
    stat[b] <= 1'b1;
    @(posedge sys_clk);
    stat[b] <= 1'b0;
    repeat (4) @(posedge sys_clk);
  endtask : pulse

  task automatic conclude();
    if (err_count == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : conclude

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    repeat (5) @(posedge sys_clk);
    chk("chan_pwr rst", chan_pwr, 16'h0054);
    chk("pll_pwr rst", pll_pwr, 16'h0030);
    rst_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    #1;
    chk("pll_pwr pre cal", pll_pwr, 16'h0036);
    rd_chk("cal word rst", pps_pkg::ADDR_CAL_WORD, 16'h0000);
    rd_chk("flags rst", pps_pkg::ADDR_FLAGS, 16'h0000);
    pulse(EV_CAL);
    chk("pll_pwr post cal", pll_pwr, 16'h0032);
  endtask : t_reset

  task automatic t_chan();
    i_pps_host_model.wr_reg(pps_pkg::ADDR_CHAN_PWR, 16'h00aa);
    #1;
    chk("chan offs", {12'h000, ch4, ch3, ch2, ch1}, 16'h000f);
    rd_chk("chan back", pps_pkg::ADDR_CHAN_PWR, 16'h00aa);
    i_pps_host_model.wr_reg(pps_pkg::ADDR_CHAN_PWR, 16'h0054);
    #1;
    chk("chan ons", {12'h000, ch4, ch3, ch2, ch1}, 16'h0000);
    // Strobe while disabled must not land
    @(posedge sys_clk);
    clk_en <= 1'b0;
    i_pps_host_model.wr_reg(pps_pkg::ADDR_CHAN_PWR, 16'h00ff);
    clk_en <= 1'b1;
    #1;
    chk("chan frozen", chan_pwr, 16'h0054);
  endtask : t_chan

  task automatic t_pll();
    i_pps_host_model.wr_reg(pps_pkg::ADDR_PLL_PWR, 16'h07c2);
    #1;
    chk("pll all off", pll_pwr, 16'h07c2);
    chk("pll offs", {14'h0000, buf2, cp}, 16'h0003);
    i_pps_host_model.wr_reg(pps_pkg::ADDR_PLL_PWR, 16'h0032);
    #1;
    chk("pll ons", {14'h0000, buf2, cp}, 16'h0000);
  endtask : t_pll

  task automatic t_flags();
    @(posedge sys_clk);
    {stat.lock_live, stat.vbuf_por, stat.freq_lock} <= 3'b111;
    {stat.cal_done, stat.cfg_done, stat.nvm_busy} <= 3'b111;
    repeat (4) @(posedge sys_clk);
    rd_chk("flags lv", pps_pkg::ADDR_FLAGS, 16'h0c1d);
    @(posedge sys_clk);
    {stat.lock_live, stat.vbuf_por, stat.freq_lock} <= 3'b000;
    {stat.cal_done, stat.cfg_done, stat.nvm_busy} <= 3'b000;
    repeat (4) @(posedge sys_clk);
    rd_chk("flags lv off", pps_pkg::ADDR_FLAGS, 16'h0000);
  endtask : t_flags

  task automatic t_ro();
    @(posedge sys_clk);
    {stat.cal_word, stat.misc} <= {16'h1234, 16'h5a5a};
    {stat.live_crc, stat.stored_crc} <= {16'hbeef, 16'h0f0f};
    for (int a = 6; a <= 10; a++) begin
      i_pps_host_model.wr_reg(8'(a), 16'hffff);
    end
    i_pps_host_model.wait_idle(ok);
    chk("idle", {15'h0000, ok}, 16'h0001);
    rd_chk("cal word", pps_pkg::ADDR_CAL_WORD, 16'h1234);
    rd_chk("flags ro", pps_pkg::ADDR_FLAGS, 16'h0000);
    rd_chk("misc", pps_pkg::ADDR_MISC, 16'h5a5a);
    rd_chk("live crc", pps_pkg::ADDR_LIVE_CRC, 16'hbeef);
    rd_chk("stored crc", pps_pkg::ADDR_STORED_CRC, 16'h0f0f);
  endtask : t_ro

  task automatic t_nvm();
    @(posedge sys_clk);
    stat.nvm_rd_phase <= 1'b1;
    pulse(EV_OP);
    rd_chk("rd phase err", pps_pkg::ADDR_FLAGS, 16'h0200);
    rd_chk("rd phase clr", pps_pkg::ADDR_FLAGS, 16'h0000);
    @(posedge sys_clk);
    {stat.nvm_rd_phase, stat.nvm_wr_phase} <= 2'b01;
    pulse(EV_OP);
    rd_chk("wr phase err", pps_pkg::ADDR_FLAGS, 16'h0100);
    rd_chk("wr phase clr", pps_pkg::ADDR_FLAGS, 16'h0000);
    @(posedge sys_clk);
    stat.nvm_wr_phase <= 1'b0;
  endtask : t_nvm

  task automatic t_crc_lock();
    pulse(EV_FAIL);
    rd_chk("crc err", pps_pkg::ADDR_FLAGS, 16'h0020);
    rd_chk("crc err kept", pps_pkg::ADDR_FLAGS, 16'h0020);
    pulse(EV_UPD);
    rd_chk("crc upd clr", pps_pkg::ADDR_FLAGS, 16'h0000);
    pulse(EV_FAIL);
    pulse(EV_LOAD);
    rd_chk("crc load clr", pps_pkg::ADDR_FLAGS, 16'h0000);
    pulse(EV_LOST);
    rd_chk("lost", pps_pkg::ADDR_FLAGS, 16'h0002);
    rd_chk("lost kept", pps_pkg::ADDR_FLAGS, 16'h0002);
    pulse(EV_RECAL);
    rd_chk("lost clr", pps_pkg::ADDR_FLAGS, 16'h0000);
  endtask : t_crc_lock

  // Sticky until reset, so this runs last
  task automatic t_bus();
    i_pps_host_model.rd_reg(pps_pkg::ADDR_LAST, rd, v);
    rd_chk("last ok", pps_pkg::ADDR_FLAGS, 16'h0000);
    i_pps_host_model.rd_reg(8'h40, rd, v);
    rd_chk("rd range", pps_pkg::ADDR_FLAGS, 16'h0080);
    i_pps_host_model.wr_reg(8'hff, 16'h1111);
    rd_chk("wr range", pps_pkg::ADDR_FLAGS, 16'h00c0);
  endtask : t_bus

  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    t_reset();
    t_chan();
    t_pll();
    t_flags();
    t_ro();
    t_nvm();
    t_crc_lock();
    t_bus();
    conclude();
  end

  // Far beyond the roughly 150 cycles the scenarios need
  initial begin
    #2000000;
    err_count++;
    conclude();
  end
endmodule : pps_regs_tb
